//--- hotswap_mfr_pkg.sv
package hotswap_mfr_pkg;
  // command codes of the vendor bank
  localparam logic [7:0] CMD_AUX_VOLTAGE   = 8'hD0;
  localparam logic [7:0] CMD_INPUT_CURRENT = 8'hD1;
  localparam logic [7:0] CMD_INPUT_POWER   = 8'hD2;
  localparam logic [7:0] CMD_CURRENT_WARN  = 8'hD3;
  localparam logic [7:0] CMD_POWER_WARN    = 8'hD4;
  localparam logic [7:0] CMD_PEAK_POWER    = 8'hD5;
  localparam logic [7:0] CMD_PEAK_CLEAR    = 8'hD6;
  localparam logic [7:0] CMD_GATE_INHIBIT  = 8'hD7;
  localparam logic [7:0] CMD_ALERT_SUPP    = 8'hD8;
  localparam logic [7:0] CMD_SETUP         = 8'hD9;

  localparam int unsigned SAMPLE_W = 12;
  localparam logic [11:0] FULL_SCALE     = 12'hFFF;
  localparam logic [11:0] ZERO12         = 12'h000;
  localparam logic [15:0] WARN_RESET     = 16'h0_FFF;
  localparam logic [15:0] ALERT_RESET    = 16'h0_820;
  localparam logic [15:0] ALERT_VALID    = 16'hF_D7F;
  localparam logic [7:0]  GATE_VALID     = 8'h3D;
  localparam logic [7:0]  SETUP_RESET    = 8'h00;
  localparam logic [7:0]  SETUP_VALID    = 8'hFC;

  // condition vector positions; only the low byte is shared by both masks
  localparam int unsigned F_CB   = 0;
  localparam int unsigned F_CML  = 1;
  localparam int unsigned F_OT   = 2;
  localparam int unsigned F_IIN  = 3;
  localparam int unsigned F_VOV  = 4;
  localparam int unsigned F_VUV  = 5;
  localparam int unsigned W_SHORT = 6;
  localparam int unsigned W_OP    = 8;
  localparam int unsigned W_OT    = 10;
  localparam int unsigned W_PGOOD = 11;
  localparam int unsigned W_VOV   = 12;
  localparam int unsigned W_VUV   = 13;
  localparam int unsigned W_IIN   = 14;
  localparam int unsigned W_VOUT  = 15;

  // setup byte fields
  localparam int unsigned SET_RETRY_HI = 7;
  localparam int unsigned SET_RETRY_LO = 5;
  localparam int unsigned SET_LIMIT    = 4;
  localparam int unsigned SET_RATIO    = 3;
  localparam int unsigned SET_SOURCE   = 2;
endpackage

//--- hotswap_mfr_command_bank.sv
`timescale 1ns/100ps
module hotswap_mfr_command_bank (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // command port from the bus engine
  input  wire logic        cmd_write,
  input  wire logic        cmd_read,
  input  wire logic        cmd_send_byte,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] cmd_rdata,
  output logic             cmd_ack,
  output logic             cmd_unsupported,
  // telemetry from the converter
  input  wire logic        sample_valid,
  input  wire logic [11:0] aux_voltage_raw,
  input  wire logic        aux_over_range,
  input  wire logic        aux_under_range,
  input  wire logic [11:0] input_current_raw,
  input  wire logic [11:0] input_voltage_raw,
  // fault and warning conditions from analog monitors
  input  wire logic [15:0] condition_in,
  input  wire logic        input_voltage_above_lockout,
  // strap pins, asynchronous
  input  wire logic [2:0]  strap_retry,
  input  wire logic        strap_limit_low,
  input  wire logic        strap_ratio_high,
  // outputs
  output logic             alert_output,
  output logic             gate_off_request,
  output logic      [15:0] status_flags,
  output logic      [2:0]  retry_select,
  output logic             limit_low_select,
  output logic             ratio_high_select,
  output logic             ocw_flag,
  output logic             opw_flag
);

  // held readings, each twelve bits wide as converted
  logic [11:0] aux_voltage_reg;
  logic [11:0] input_current_reg;
  logic [11:0] input_power_reg;
  logic [11:0] peak_power_reg;
  logic [15:0] current_warn_reg;
  logic [15:0] power_warn_reg;
  logic [7:0]  gate_inhibit_reg;
  logic [15:0] alert_suppress_reg;
  logic [7:0]  setup_reg;
  logic        uv_startup_reg;
  logic        ocw_reg;
  logic        opw_reg;
  // strap synchroniser, two stages
  logic [4:0]  strap_meta_reg;
  logic [4:0]  strap_sync_reg;
  // combinational helpers
  logic [23:0] power_product;
  logic [11:0] power_next;
  logic [11:0] aux_next;
  logic [15:0] cond_all;
  // decoded command strobes
  logic        wr_current_warn;
  logic        wr_power_warn;
  logic        wr_gate_inhibit;
  logic        wr_alert_suppress;
  logic        wr_setup;
  logic        peak_clear_cmd;
  logic        rd_known;
  logic [15:0] rdata_next;
  logic [15:0] alert_hits;
  logic [7:0]  gate_hits;

  // a threshold of all ones means the warning is off; the compare is on the
  // whole word, so a threshold above 0fff can never trip either
  function automatic logic over_warn(input logic [11:0] val, input logic [15:0] lim);
    over_warn = (lim[11:0] != hotswap_mfr_pkg::FULL_SCALE) && ({4'h0, val} > lim);
  endfunction

  // one strobe aimed at one command code; shared by write, clear and support decode
  function automatic logic cmd_hit(input logic strobe, input logic [7:0] code, input logic [7:0] want);
    cmd_hit = strobe && (code == want);
  endfunction

  // straps pass two flops before use; the pins are not tied to ref_clk, so
  // only the second stage may feed logic, and a strap change shows up two
  // cycles late, which is harmless for static configuration
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_meta_reg <= 5'h00;
      strap_sync_reg <= 5'h00;
    end else begin
      strap_meta_reg <= {strap_retry, strap_limit_low, strap_ratio_high};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // power product: keep only the upper twelve bits; the low half is
  // dropped on purpose, twelve bits is all the reading carries
  assign power_product = input_voltage_raw * input_current_raw;
  assign power_next    = power_product[23:12];

  // command strobes, decoded once so each register process stays small
  assign wr_current_warn   = cmd_hit(cmd_write, cmd_code, hotswap_mfr_pkg::CMD_CURRENT_WARN);
  assign wr_power_warn     = cmd_hit(cmd_write, cmd_code, hotswap_mfr_pkg::CMD_POWER_WARN);
  assign wr_gate_inhibit   = cmd_hit(cmd_write, cmd_code, hotswap_mfr_pkg::CMD_GATE_INHIBIT);
  assign wr_alert_suppress = cmd_hit(cmd_write, cmd_code, hotswap_mfr_pkg::CMD_ALERT_SUPP);
  assign wr_setup          = cmd_hit(cmd_write, cmd_code, hotswap_mfr_pkg::CMD_SETUP);
  assign peak_clear_cmd    = cmd_hit(cmd_send_byte, cmd_code, hotswap_mfr_pkg::CMD_PEAK_CLEAR);

  // aux clamp, converter range flags override the code, since the code
  // itself may wrap when the input leaves the converter's range
  always_comb begin
    if (aux_over_range) begin
      aux_next = hotswap_mfr_pkg::FULL_SCALE;
    end else if (aux_under_range) begin
      aux_next = hotswap_mfr_pkg::ZERO12;
    end else begin
      aux_next = aux_voltage_raw;
    end
  end

  // aux voltage reading, clamped at capture time
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      aux_voltage_reg <= hotswap_mfr_pkg::ZERO12;
    end else if (sample_valid) begin
      aux_voltage_reg <= aux_next;
    end
  end

  // input current reading, taken straight from the converter
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      input_current_reg <= hotswap_mfr_pkg::ZERO12;
    end else if (sample_valid) begin
      input_current_reg <= input_current_raw;
    end
  end

  // input power reading; captured with the others so the three stay aligned
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      input_power_reg <= hotswap_mfr_pkg::ZERO12;
    end else if (sample_valid) begin
      input_power_reg <= power_next;
    end
  end

  // peak tracking; a clear in the same cycle as a sample restarts from it,
  // so a sample landing on the clear is never lost from the new peak
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      peak_power_reg <= hotswap_mfr_pkg::ZERO12;
    end else if (peak_clear_cmd) begin
      peak_power_reg <= sample_valid ? power_next : hotswap_mfr_pkg::ZERO12;
    end else if (sample_valid && power_next > peak_power_reg) begin
      peak_power_reg <= power_next;
    end
  end

  // current warning per sample; the flag follows the latest sample, not sticky
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ocw_reg <= 1'b0;
    end else if (sample_valid) begin
      ocw_reg <= over_warn(input_current_raw, current_warn_reg);
    end
  end

  // power warning per sample; there is no power fault, only this flag
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      opw_reg <= 1'b0;
    end else if (sample_valid) begin
      opw_reg <= over_warn(power_next, power_warn_reg);
    end
  end

  // undervoltage fault holds from startup until input first passes lockout;
  // it never sets again here, later undervoltage arrives on condition_in
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      uv_startup_reg <= 1'b1;
    end else if (input_voltage_above_lockout) begin
      uv_startup_reg <= 1'b0;
    end
  end

  // current warning threshold; stored whole, and all sixteen bits take part in the compare
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      current_warn_reg <= hotswap_mfr_pkg::WARN_RESET;
    end else if (wr_current_warn) begin
      current_warn_reg <= cmd_wdata;
    end
  end

  // power warning threshold
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      power_warn_reg <= hotswap_mfr_pkg::WARN_RESET;
    end else if (wr_power_warn) begin
      power_warn_reg <= cmd_wdata;
    end
  end

  // gate inhibit; unused bits are dropped so they always read zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gate_inhibit_reg <= 8'h00;
    end else if (wr_gate_inhibit) begin
      gate_inhibit_reg <= cmd_wdata[7:0] & hotswap_mfr_pkg::GATE_VALID;
    end
  end

  // alert suppress; unused bits are dropped at write time
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      alert_suppress_reg <= hotswap_mfr_pkg::ALERT_RESET;
    end else if (wr_alert_suppress) begin
      alert_suppress_reg <= cmd_wdata & hotswap_mfr_pkg::ALERT_VALID;
    end
  end

  // host setup byte; bits 1:0 are unused and dropped
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      setup_reg <= hotswap_mfr_pkg::SETUP_RESET;
    end else if (wr_setup) begin
      setup_reg <= cmd_wdata[7:0] & hotswap_mfr_pkg::SETUP_VALID;
    end
  end

  // merged condition vector, local warnings and startup flag folded in;
  // bit 8 from outside is ignored, the power warning is made here only
  always_comb begin
    cond_all = condition_in;
    cond_all[hotswap_mfr_pkg::W_IIN] = condition_in[hotswap_mfr_pkg::W_IIN] | ocw_reg;
    cond_all[hotswap_mfr_pkg::W_OP]  = opw_reg;
    cond_all[hotswap_mfr_pkg::F_VUV] = condition_in[hotswap_mfr_pkg::F_VUV] | uv_startup_reg;
    cond_all = cond_all & hotswap_mfr_pkg::ALERT_VALID;
  end

  // per-bit alert contributions: a masked condition still lands in status
  for (genvar i = 0; i < 16; i++) begin : g_alert_hit
    assign alert_hits[i] = cond_all[i] & ~alert_suppress_reg[i];
  end

  // per-bit gate contributions: only fault positions 0 and 2 to 5 may open the switch
  for (genvar i = 0; i < 8; i++) begin : g_gate_hit
    assign gate_hits[i] = cond_all[i] & hotswap_mfr_pkg::GATE_VALID[i] & ~gate_inhibit_reg[i];
  end

  // alert raised by any condition the host has not suppressed
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      alert_output <= 1'b0;
    end else begin
      alert_output <= |alert_hits;
    end
  end

  // gate request; the power warning sits at bit 8 and never reaches it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gate_off_request <= 1'b0;
    end else begin
      gate_off_request <= |gate_hits;
    end
  end

  // status keeps every condition, masked or not
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      status_flags <= 16'h0_000;
    end else begin
      status_flags <= cond_all;
    end
  end

  // retry select: 000 hands the choice back to the straps
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      retry_select <= 3'h0;
    end else begin
      retry_select <= (setup_reg[hotswap_mfr_pkg::SET_RETRY_HI:hotswap_mfr_pkg::SET_RETRY_LO] == 3'h0)
                      ? strap_sync_reg[4:2]
                      : setup_reg[hotswap_mfr_pkg::SET_RETRY_HI:hotswap_mfr_pkg::SET_RETRY_LO];
    end
  end

  // limit and ratio: register values only when the source bit is set
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      limit_low_select  <= 1'b0;
      ratio_high_select <= 1'b0;
    end else if (setup_reg[hotswap_mfr_pkg::SET_SOURCE]) begin
      limit_low_select  <= setup_reg[hotswap_mfr_pkg::SET_LIMIT];
      ratio_high_select <= setup_reg[hotswap_mfr_pkg::SET_RATIO];
    end else begin
      limit_low_select  <= strap_sync_reg[1];
      ratio_high_select <= strap_sync_reg[0];
    end
  end

  // read decode; unknown codes return zero and are flagged unsupported
  always_comb begin
    rdata_next = 16'h0_000;
    rd_known   = 1'b1;
    case (cmd_code)
      hotswap_mfr_pkg::CMD_AUX_VOLTAGE:   rdata_next = {4'h0, aux_voltage_reg};
      hotswap_mfr_pkg::CMD_INPUT_CURRENT: rdata_next = {4'h0, input_current_reg};
      hotswap_mfr_pkg::CMD_INPUT_POWER:   rdata_next = {4'h0, input_power_reg};
      hotswap_mfr_pkg::CMD_CURRENT_WARN:  rdata_next = current_warn_reg;
      hotswap_mfr_pkg::CMD_POWER_WARN:    rdata_next = power_warn_reg;
      hotswap_mfr_pkg::CMD_PEAK_POWER:    rdata_next = {4'h0, peak_power_reg};
      hotswap_mfr_pkg::CMD_GATE_INHIBIT:  rdata_next = {8'h00, gate_inhibit_reg};
      hotswap_mfr_pkg::CMD_ALERT_SUPP:    rdata_next = alert_suppress_reg;
      hotswap_mfr_pkg::CMD_SETUP:         rdata_next = {8'h00, setup_reg};
      default:                            rd_known   = 1'b0;
    endcase
  end

  // read data register; holds until the next read so a slow host can take it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_rdata <= 16'h0_000;
    end else if (cmd_read) begin
      cmd_rdata <= rdata_next;
    end
  end

  // acknowledge one cycle after every request, whatever its code
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_ack <= 1'b0;
    end else begin
      cmd_ack <= cmd_read | cmd_write | cmd_send_byte;
    end
  end

  // unsupported: unknown read code, or a send-byte that is not peak clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_unsupported <= 1'b0;
    end else begin
      cmd_unsupported <= (cmd_read && !rd_known) || (cmd_send_byte && !peak_clear_cmd);
    end
  end

  // warning flags leave as plain copies of their registers
  assign ocw_flag = ocw_reg;
  assign opw_flag = opw_reg;

endmodule // hotswap_mfr_command_bank

//--- hotswap_mfr_properties.sv
`timescale 1ns/100ps
module hotswap_mfr_properties (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        cmd_write,
  input wire logic        cmd_read,
  input wire logic        cmd_send_byte,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic        cmd_ack,
  input wire logic        cmd_unsupported,
  input wire logic        sample_valid,
  input wire logic [11:0] input_current_raw,
  input wire logic        ocw_flag,
  input wire logic        opw_flag,
  input wire logic [15:0] status_flags
);
  logic [15:0] thr_reg;
  // shadow of the current threshold, so the trip point is judged independently
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) thr_reg <= 16'h0FFF;
    else if (cmd_write && cmd_code == 8'hD3) thr_reg <= cmd_wdata;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // clear followed two cycles later by a peak read, no sample in between
  sequence s_clear; cmd_send_byte && cmd_code == 8'hD6 && !sample_valid; endsequence
  sequence s_peak_rd; !sample_valid ##1 cmd_read && cmd_code == 8'hD5 && !sample_valid; endsequence
  ack_follows_a: assert property ((cmd_read || cmd_write || cmd_send_byte) |=> cmd_ack)
    else $error("no ack after request");
  ack_cause_a: assert property (cmd_ack |-> $past(cmd_read || cmd_write || cmd_send_byte))
    else $error("ack without request");
  send_code_a: assert property (cmd_send_byte |=> cmd_unsupported == ($past(cmd_code) != 8'hD6))
    else $error("send-byte support flag wrong");
  word_upper_a: assert property (cmd_read && (cmd_code == 8'hD0 || cmd_code == 8'hD2) |=> cmd_rdata[15:12] == 4'h0)
    else $error("reading upper bits set");
  peak_clear_a: assert property (s_clear ##1 s_peak_rd |=> cmd_rdata == 16'h0000)
    else $error("peak not cleared");
  ocw_trip_a: assert property (sample_valid && thr_reg[11:0] != 12'hFFF && {4'h0, input_current_raw} > thr_reg |=> ocw_flag)
    else $error("current warning missed");
  ocw_disabled_a: assert property (sample_valid && thr_reg[11:0] == 12'hFFF |=> !ocw_flag)
    else $error("disabled warning tripped");
  ocw_status_a: assert property (ocw_flag |=> status_flags[14])
    else $error("current warning not in status");
  opw_status_a: assert property (opw_flag |=> status_flags[8])
    else $error("power warning not in status");
endmodule // hotswap_mfr_properties
bind hotswap_mfr_command_bank hotswap_mfr_properties u_props (.*);

//--- hotswap_host_model.sv
`timescale 1ns/100ps
// host issuing one command at a time; released lines are scrambled
module hotswap_host_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] cmd_rdata,
  input  wire logic        cmd_ack,
  output logic             cmd_write,
  output logic             cmd_read,
  output logic             cmd_send_byte,
  output logic      [7:0]  cmd_code,
  output logic      [15:0] cmd_wdata
);
  // idle bus before the first command
  initial begin
    {cmd_write, cmd_read, cmd_send_byte} = 3'h0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // k: 0 read word, 1 write, 2 send-byte; request is a one-cycle pulse
  task automatic xfer(input int k, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic a);
    @(posedge ref_clk);
    #1;
    cmd_read = (k == 0);
    cmd_write = (k == 1);
    cmd_send_byte = (k == 2);
    cmd_code = c;
    cmd_wdata = d;
    @(posedge ref_clk);
    #1;
    {cmd_write, cmd_read, cmd_send_byte} = 3'h0;
    cmd_code = ~c;
    cmd_wdata = ~d;
    q = cmd_rdata;
    a = cmd_ack;
  endtask
endmodule // hotswap_host_model

//--- hotswap_mfr_command_bank_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module hotswap_mfr_command_bank_tb;
  logic        ref_clk = 1'b0, rstn = 1'b0, cmd_write, cmd_read, cmd_send_byte, cmd_ack, cmd_unsupported;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, status_flags, condition_in = 16'h0000;
  logic        sample_valid = 1'b0, aux_over_range = 1'b0, aux_under_range = 1'b0;
  logic [11:0] aux_voltage_raw = 12'h000, input_current_raw = 12'h000, input_voltage_raw = 12'h000;
  logic        input_voltage_above_lockout = 1'b0, strap_limit_low = 1'b0, strap_ratio_high = 1'b0;
  logic [2:0]  strap_retry = 3'h5, retry_select;
  logic        alert_output, gate_off_request, limit_low_select, ratio_high_select, ocw_flag, opw_flag;
  logic [15:0] exp_rst [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0FFF, 16'h0FFF, 16'h0000, 16'h0000,
                                16'h0000, 16'h0820, 16'h0000};
  int          n_mismatch = 0, checked = 0, cyc = 0;

  hotswap_mfr_command_bank DUT (.*);
  hotswap_host_model HOST (.*);

  // free-running clock and a hang guard well above the expected run
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] q;
    logic        a;
    HOST.xfer(0, c, 16'h0000, q, a);
    `CHK(a, 1'b1)
    `CHK(q, e)
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int k = 1);
    logic [15:0] q;
    logic        a;
    HOST.xfer(k, c, d, q, a);
    `CHK(a, 1'b1)
  endtask
  // one converter sample, then wait for alert and status to follow
  task automatic smp(input logic [11:0] x, i, v, input logic o = 1'b0, u = 1'b0);
    @(posedge ref_clk);
    #1;
    {aux_voltage_raw, input_current_raw, input_voltage_raw} = {x, i, v};
    {aux_over_range, aux_under_range, sample_valid} = {o, u, 1'b1};
    @(posedge ref_clk);
    #1;
    sample_valid = 1'b0;
    settle();
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    settle();
    `CHK(retry_select, 3'h5)
    `CHK({status_flags[5], alert_output, gate_off_request}, 3'h5)
    input_voltage_above_lockout = 1'b1;
    settle();
    `CHK({status_flags[5], gate_off_request}, 2'h0)
    for (int i = 0; i < 10; i++) if (i != 6) rd(8'hD0 + i[7:0], exp_rst[i]);
    wr(8'hD0, 16'h5555);
    rd(8'hD0, 16'h0000);
    wr(8'hD7, 16'hFFFF);
    rd(8'hD7, 16'h003D);
    wr(8'hD8, 16'hFFFF);
    rd(8'hD8, 16'hFD7F);
    wr(8'hD8, 16'h0820);
    wr(8'hD7, 16'h0000);
    smp(12'h123, 12'h800, 12'h800);
    rd(8'hD0, 16'h0123);
    rd(8'hD1, 16'h0800);
    rd(8'hD2, 16'h0400);
    smp(12'h456, 12'h100, 12'h800, 1'b1);
    rd(8'hD0, 16'h0FFF);
    smp(12'h456, 12'h100, 12'h800, 1'b0, 1'b1);
    rd(8'hD0, 16'h0000);
    rd(8'hD5, 16'h0400);
    wr(8'hD5, 16'h0000, 2);
    wr(8'hD6, 16'h0000, 2);
    rd(8'hD5, 16'h0000);
    wr(8'hD3, 16'h07FF);
    smp(12'h000, 12'h800, 12'h100);
    `CHK({ocw_flag, alert_output}, 2'h3)
    wr(8'hD3, 16'h0FFF);
    smp(12'h000, 12'h800, 12'h100);
    `CHK({ocw_flag, alert_output}, 2'h0)
    wr(8'hD4, 16'h03FF);
    smp(12'h000, 12'h800, 12'h800);
    `CHK({opw_flag, alert_output, gate_off_request}, 3'h6)
    wr(8'hD8, 16'h0920);
    smp(12'h000, 12'h800, 12'h800);
    `CHK({opw_flag, alert_output, status_flags[8]}, 3'h5)
    condition_in = 16'h0010;
    smp(12'h000, 12'h800, 12'h800);
    `CHK({gate_off_request, alert_output}, 2'h3)
    wr(8'hD7, 16'h0010);
    smp(12'h000, 12'h800, 12'h800);
    `CHK({gate_off_request, alert_output, status_flags[4]}, 3'h3)
    wr(8'hD9, 16'h00FF);
    rd(8'hD9, 16'h00FC);
    `CHK(retry_select, 3'h7)
    wr(8'hD9, 16'h0020);
    settle();
    `CHK(retry_select, 3'h1)
    wr(8'hD9, 16'h0018);
    settle();
    `CHK({retry_select, limit_low_select, ratio_high_select}, 5'h14)
    wr(8'hD9, 16'h001C);
    settle();
    `CHK({retry_select, limit_low_select, ratio_high_select}, 5'h17)
    tally_and_finish();
  end
endmodule // hotswap_mfr_command_bank_tb
